// ---- bench/sar_adc_control_mux_select_bench.sv ----
/*
 * self-checking bench for the converter control block.
 * assumes the far side model sar_far_side and a 20 MHz system clock.
 */
`default_nettype none

module sar_adc_control_mux_select_bench
    import sar_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        clk, rst_n, we, re, ext, sleep, comp, t3, t2;
    logic        pwr, track, diff, temp, irq;
    logic [7:0]  addr, wdata, rdata, d, h, l, got8;
    logic [2:0]  pos, neg, gain, g;
    logic [3:0]  p, s;
    logic [11:0] code, level;
    logic [1:0]  fire;
    int          seed, n_fail, cmp_count, n, dv;
    logic [7:0]  rst_ofs [5] = '{OFS_CTRL, OFS_CFG, OFS_SEL, OFS_PAIR, 8'h07};
    logic [7:0]  rst_val [5] = '{CTRL_RST, CFG_RST, {4'h0, SEL_RST}, {4'h0, PAIR_RST}, 8'h00};

    sar_adc_ctl dut (.CLK_I(clk), .RST_N_I(rst_n), .SFR_WE_I(we), .SFR_RE_I(re),
        .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata), .TMR3_OVF_I(t3), .TMR2_OVF_I(t2),
        .EXT_START_I(ext), .SLEEP_I(sleep), .COMP_I(comp), .SFR_RDATA_O(rdata),
        .CONV_POWER_O(pwr), .TRACK_O(track), .MUX_POS_O(pos), .MUX_NEG_O(neg),
        .DIFF_O(diff), .TEMP_SEL_O(temp), .GAIN_O(gain), .SAR_CODE_O(code), .IRQ_O(irq));

    sar_far_side far (.code_i(code), .level_i(level), .fire_i(fire), .comp_o(comp),
        .tmr3_o(t3), .tmr2_o(t2));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------
    // tasks and expectations
    // ----------------------------------------
    task automatic cyc();
        @(posedge clk);
        #2;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        cyc();
        we = 1'b1;
        addr = a;
        wdata = v;
        cyc();
        we = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        cyc();
        re = 1'b1;
        addr = a;
        cyc();
        re = 1'b0;
        v = rdata;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // polls the done flag, never busy; bounded so a hang ends the loop
    task automatic wait_done(output int c);
        c = 0;
        d = 8'h00;
        while (d[BIT_DONE] !== 1'b1 && c < 800)
        begin
            rd(OFS_CTRL, d);
            c += 2;
        end
    endtask

    function automatic logic [7:0] mux_exp(input logic [3:0] pc, input logic [3:0] sc);
        if (sc[3])
            return 8'h80;
        if (pc[sc[2:1]])
            return {2'b01, sc[2:1], 1'b0, sc[2:1], 1'b1};
        return {2'b00, sc[2:0], 3'h0};
    endfunction

    task automatic summarize();
        if (n_fail == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        seed = 34;
        n_fail = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        {we, re, ext, sleep, fire, addr, wdata, level} = '0;
        repeat (16) @(posedge clk);
        #2;
        rst_n = 1'b1;
        foreach (rst_ofs[i])
        begin
            rd(rst_ofs[i], d);
            chk(16'(d), 16'(rst_val[i]));
        end
        chk(16'({pwr, gain}), 16'h0);
        for (int i = 0; i < 24; i++)
        begin
            p = 4'($random(seed));
            s = (i < 2) ? {1'b1, 3'(i)} : 4'($random(seed));
            g = 3'($random(seed));
            wr(OFS_PAIR, {4'h0, p});
            wr(OFS_SEL, {4'h0, s});
            wr(OFS_CFG, {3'h3, 2'h0, g});
            cyc();
            got8 = s[3] ? {temp, 7'h0} : {temp, diff, pos, diff ? neg : 3'h0};
            chk(16'(got8), 16'(mux_exp(p, s)));
            chk(16'(gain), 16'(g));
        end
        // bias and reference taken as set up before the converter is enabled
        wr(OFS_CTRL, 8'h80);
        repeat (2) cyc();
        chk(16'({pwr, track}), 16'h3);
        sleep = 1'b1;
        repeat (2) cyc();
        chk(16'(track), 16'h0);
        sleep = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            level = (k == 0) ? 12'hfff : 12'($random(seed));
            dv = 2 << k;
            wr(OFS_CFG, {3'(k), 5'h0});
            repeat (210) cyc();
            wr(OFS_CTRL, 8'h92 | 8'(k & 1));
            rd(OFS_CTRL, d);
            chk(16'({d[BIT_BUSY], track}), 16'h2);
            wait_done(n);
            chk(16'(d[BIT_BUSY]), 16'h0);
            chk(16'(n >= 11 * dv - 4 && n <= 12 * dv + 8), 16'h1);
            repeat (2) cyc();
            chk(16'(irq), 16'h1);
            rd(OFS_RES_H, h);
            rd(OFS_RES_L, l);
            chk({h, l}, (k & 1) ? {level, 4'h0} : {4'h0, level});
            wr(OFS_CTRL, 8'h82);
            repeat (2) cyc();
            chk(16'(irq), 16'h0);
        end
        for (int m = 1; m < 4; m++)
        begin
            wr(OFS_CTRL, 8'h80 | 8'(m << 2));
            repeat (210) cyc();
            fire = (m == 3) ? 2'b01 : 2'b10;
            cyc();
            fire = 2'b00;
            rd(OFS_CTRL, d);
            chk(16'(d[BIT_BUSY]), 16'h0);
            ext = (m == 2);
            fire = (m == 1) ? 2'b01 : (m == 3) ? 2'b10 : 2'b00;
            cyc();
            fire = 2'b00;
            wait_done(n);
            chk(16'(d[BIT_DONE]), 16'h1);
            wr(OFS_CTRL, 8'h80 | 8'(m << 2));
            repeat (250) cyc();
            rd(OFS_CTRL, d);
            chk(16'(d[BIT_DONE]), 16'h0);
            ext = 1'b0;
        end
        wr(OFS_CTRL, 8'hc8);
        repeat (5) cyc();
        chk(16'(track), 16'h1);
        ext = 1'b1;
        repeat (5) cyc();
        chk(16'(track), 16'h0);
        repeat (250) cyc();
        wr(OFS_CTRL, 8'hd0);
        cyc();
        n = 0;
        while (track === 1'b1 && n < 100)
        begin
            cyc();
            n++;
        end
        chk(16'(n >= 30 && n <= 50), 16'h1);
        summarize();
    end
endmodule

`default_nettype wire

// ---- bench/sar_far_side.sv ----
/*
 * far side model: comparator against a held analog level, timer overflows.
 * assumes the bench sets the level and asks for overflow pulses one clock long.
 */
`default_nettype none

module sar_far_side
(
    input  wire logic [11:0] code_i,
    input  wire logic [11:0] level_i,
    input  wire logic [1:0]  fire_i,
    output logic             comp_o,
    output logic             tmr3_o,
    output logic             tmr2_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // comparator and timers
    // ----------------------------------------
    // answers within the same cycle, as the macro does
    assign comp_o = (level_i >= code_i);
    // bench holds fire for exactly one clock, so these are overflow pulses
    assign tmr3_o = fire_i[0];
    assign tmr2_o = fire_i[1];
endmodule

`default_nettype wire

// ---- design/conv_clk_div.sv ----
/*
 * conversion clock divider: one-cycle tick every 2, 4, 8 or 16 system clocks.
 * assumes the scale code comes from a register on the same clock.
 */
`default_nettype none

module conv_clk_div
    import sar_ctl_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    conv_timing_if.div      tif
);

    // ----------------------------------------
    // divider
    // ----------------------------------------
    function automatic logic [3:0] div_limit(input logic [2:0] sc);
        unique case (sc)
            3'h0:    div_limit = 4'h1;
            3'h1:    div_limit = 4'h3;
            3'h2:    div_limit = 4'h7;
            default: div_limit = 4'hf;
        endcase
    endfunction

    logic [3:0] cnt_r;
    logic       tick_r;

    // a scale change mid-count just wraps early, never stalls
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r  <= 4'h0;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= (cnt_r >= div_limit(tif.scale));
            cnt_r  <= (cnt_r >= div_limit(tif.scale)) ? 4'h0 : cnt_r + 4'h1;
        end
    end

    assign tif.tick = tick_r;

endmodule

`default_nettype wire

// ---- design/conv_timing_if.sv ----
/*
 * carrier between the control core, the clock divider and the pin synchroniser.
 * assumes all three sit on the one system clock.
 */
`default_nettype none

interface conv_timing_if;
    logic [2:0] scale;
    logic       tick;
    logic       ext_level;
    logic       ext_rise;

    modport div  (input scale, output tick);
    modport sync (output ext_level, output ext_rise);
    modport ctl  (output scale, input tick, input ext_level, input ext_rise);
endinterface

`default_nettype wire

// ---- design/ext_start_sync.sv ----
/*
 * two-flop synchroniser and rising edge detector for the external start pin.
 * assumes the pin is asynchronous to the system clock.
 */
`default_nettype none

module ext_start_sync
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       pin_i,
    conv_timing_if.sync     tif
);

    // ----------------------------------------
    // synchroniser
    // ----------------------------------------
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            meta_r <= pin_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign tif.ext_level = sync_r;
    assign tif.ext_rise  = sync_r & ~prev_r;

endmodule

`default_nettype wire

// ---- design/sar_adc_ctl.sv ----
/*
 * control logic of a 12-bit successive approximation converter: register
 * file, input selection, gain, start sources, track-and-hold and sar sequence.
 * assumes the analog macro answers COMP_I on the same clock within one cycle
 * of SAR_CODE_O, and that timer overflows are one-cycle pulses on this clock.
 */
// ----------------------------------------
// Summary of operation
// - converter, track-and-hold and gain powered only while enable bit is set
// - nine inputs: eight external plus internal temperature sensor
// - selected gain also applies to the temperature sensor channel
// - pairs independently differential or single-ended; all single-ended after reset
// - pair bit joins even (positive) and odd (negative) neighbouring inputs
// - channel address 0-7 selects input or its pair; 1xxx selects sensor
// - three-bit gain field picks 0.5 to 16; unity after reset
// - conversion clock is system clock over 2/4/8/16; at most 100 ksps
// - start mode picks software, timer 3, external edge or timer 2
// - busy reads 1 during conversion, 0 once finished
// - busy falling edge sets done flag and requests enabled interrupt
// - result left justified when justify bit set, else right justified
// - track mode 0 tracks continuously except while converting
// - track mode 1 with non-external start tracks three conversion clocks
// - track mode 1 with external start tracks only while the pin is low
// - tracking can be shut down during chip standby or sleep
// ----------------------------------------
`default_nettype none

module sar_adc_ctl
    import sar_ctl_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        SFR_WE_I,
    input  wire logic        SFR_RE_I,
    input  wire logic [7:0]  SFR_ADDR_I,
    input  wire logic [7:0]  SFR_WDATA_I,
    input  wire logic        TMR3_OVF_I,
    input  wire logic        TMR2_OVF_I,
    input  wire logic        EXT_START_I,
    input  wire logic        SLEEP_I,
    input  wire logic        COMP_I,
    output logic [7:0]       SFR_RDATA_O,
    output logic             CONV_POWER_O,
    output logic             TRACK_O,
    output logic [2:0]       MUX_POS_O,
    output logic [2:0]       MUX_NEG_O,
    output logic             DIFF_O,
    output logic             TEMP_SEL_O,
    output logic [2:0]       GAIN_O,
    output logic [11:0]      SAR_CODE_O,
    output logic             IRQ_O
);

    // ----------------------------------------
    // sub-blocks
    // ----------------------------------------
    conv_timing_if tif ();

    conv_clk_div u_div
    (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .tif     (tif)
    );

    ext_start_sync u_sync
    (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .pin_i   (EXT_START_I),
        .tif     (tif)
    );

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic        en_r;
    logic        tm_r;
    logic        done_r;
    start_mode_t mode_r;
    logic        irq_en_r;
    logic        lj_r;
    logic [2:0]  scale_r;
    logic [2:0]  gain_r;
    logic [3:0]  sel_r;
    logic [3:0]  pair_r;
    logic [11:0] result_r;
    logic        wr_ctrl;
    logic        wr_cfg;
    logic        wr_sel;
    logic        wr_pair;
    logic        sw_start;

    assign wr_ctrl  = SFR_WE_I && (SFR_ADDR_I == OFS_CTRL);
    assign wr_cfg   = SFR_WE_I && (SFR_ADDR_I == OFS_CFG);
    assign wr_sel   = SFR_WE_I && (SFR_ADDR_I == OFS_SEL);
    assign wr_pair  = SFR_WE_I && (SFR_ADDR_I == OFS_PAIR);
    // mode written in the same access counts, so one write can set mode and start
    assign sw_start = wr_ctrl && SFR_WDATA_I[BIT_BUSY]
                      && (SFR_WDATA_I[BIT_MODE +: 2] == START_SW);

    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            en_r     <= CTRL_RST[BIT_EN];
            tm_r     <= CTRL_RST[BIT_TM];
            mode_r   <= start_mode_t'(CTRL_RST[BIT_MODE +: 2]);
            irq_en_r <= CTRL_RST[BIT_IRQEN];
            lj_r     <= CTRL_RST[BIT_LJ];
        end
        else if (wr_ctrl)
        begin
            en_r     <= SFR_WDATA_I[BIT_EN];
            tm_r     <= SFR_WDATA_I[BIT_TM];
            mode_r   <= start_mode_t'(SFR_WDATA_I[BIT_MODE +: 2]);
            irq_en_r <= SFR_WDATA_I[BIT_IRQEN];
            lj_r     <= SFR_WDATA_I[BIT_LJ];
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            scale_r <= CFG_RST[BIT_SCALE +: 3];
            gain_r  <= CFG_RST[2:0];
            sel_r   <= SEL_RST;
            pair_r  <= PAIR_RST;
        end
        else
        begin
            if (wr_cfg)
            begin
                scale_r <= SFR_WDATA_I[BIT_SCALE +: 3];
                gain_r  <= SFR_WDATA_I[2:0];
            end
            if (wr_sel)
            begin
                sel_r <= SFR_WDATA_I[3:0];
            end
            if (wr_pair)
            begin
                pair_r <= SFR_WDATA_I[3:0];
            end
        end
    end

    assign tif.scale = scale_r;

    // ----------------------------------------
    // start selection and rate limit
    // ----------------------------------------
    conv_state_t state_r;
    logic        trig;
    logic        trk_first;
    logic        start_go;
    logic [7:0]  rate_cnt_r;

    always_comb
    begin
        unique case (mode_r)
            START_SW:   trig = sw_start;
            START_TMR3: trig = sw_start || TMR3_OVF_I;
            START_EXT:  trig = sw_start || tif.ext_rise;
            START_TMR2: trig = sw_start || TMR2_OVF_I;
        endcase
    end

    // a software start takes its track mode from the written bits, not the old ones
    assign trk_first = sw_start ? SFR_WDATA_I[BIT_TM] : (tm_r && (mode_r != START_EXT));

    // triggers landing while busy or too soon are dropped, not queued
    assign start_go = (state_r == ST_IDLE) && en_r && (rate_cnt_r == 8'h00) && trig;

    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            rate_cnt_r <= 8'h00;
        end
        else if (start_go)
        begin
            rate_cnt_r <= RATE_LOAD;
        end
        else if (rate_cnt_r != 8'h00)
        begin
            rate_cnt_r <= rate_cnt_r - 8'h01;
        end
    end

    // ----------------------------------------
    // sar sequence
    // ----------------------------------------
    logic [1:0]  trk_cnt_r;
    logic [3:0]  bit_r;
    logic [11:0] trial_r;
    logic [11:0] cur_mask;
    logic [11:0] decided;

    assign cur_mask = 12'h001 << bit_r;
    assign decided  = COMP_I ? trial_r : (trial_r & ~cur_mask);

    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            state_r   <= ST_IDLE;
            trk_cnt_r <= 2'h0;
            bit_r     <= MSB_INDEX;
            trial_r   <= 12'h000;
            result_r  <= 12'h000;
        end
        else if (!en_r)
        begin
            state_r <= ST_IDLE;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    if (start_go)
                    begin
                        trk_cnt_r <= 2'h0;
                        bit_r     <= MSB_INDEX;
                        trial_r   <= TRIAL_INIT;
                        state_r   <= trk_first ? ST_TRACK : ST_CONV;
                    end
                end
                ST_TRACK:
                begin
                    if (tif.tick)
                    begin
                        if (trk_cnt_r == TRACK_LAST)
                        begin
                            state_r <= ST_CONV;
                        end
                        trk_cnt_r <= trk_cnt_r + 2'h1;
                    end
                end
                ST_CONV:
                begin
                    if (tif.tick)
                    begin
                        trial_r <= decided | (cur_mask >> 1);
                        if (bit_r == 4'h0)
                        begin
                            result_r <= decided;
                            state_r  <= ST_IDLE;
                        end
                        else
                        begin
                            bit_r <= bit_r - 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // busy, done flag and interrupt
    // ----------------------------------------
    logic busy;
    logic busy_d_r;
    logic busy_fall;
    logic irq_r;

    assign busy      = (state_r != ST_IDLE);
    assign busy_fall = busy_d_r && !busy;

    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            busy_d_r <= 1'b0;
            done_r   <= CTRL_RST[BIT_DONE];
            irq_r    <= 1'b0;
        end
        else
        begin
            busy_d_r <= busy;
            // a completion in the clearing cycle still sets the flag
            done_r   <= busy_fall || (wr_ctrl ? (done_r && SFR_WDATA_I[BIT_DONE]) : done_r);
            irq_r    <= done_r && irq_en_r;
        end
    end

    // ----------------------------------------
    // input selection, gain, power and tracking
    // ----------------------------------------
    function automatic logic [7:0] chan_decode(input logic [3:0] sel, input logic [3:0] pairs);
        logic [1:0] pr;
        pr = sel[2:1];
        if (sel[3])
        begin
            chan_decode = 8'h80;
        end
        else if (pairs[pr])
        begin
            chan_decode = {2'b01, pr, 1'b1, pr, 1'b0};
        end
        else
        begin
            chan_decode = {2'b00, 3'h0, sel[2:0]};
        end
    endfunction

    logic [7:0] mux_r;
    logic       power_r;
    logic       track_r;
    logic       track_nxt;

    always_comb
    begin
        if (!en_r || SLEEP_I)
        begin
            track_nxt = 1'b0;
        end
        else if (!tm_r)
        begin
            track_nxt = (state_r == ST_IDLE);
        end
        else if (mode_r == START_EXT)
        begin
            track_nxt = (state_r == ST_IDLE) && !tif.ext_level;
        end
        else
        begin
            track_nxt = (state_r == ST_TRACK);
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            mux_r   <= 8'h00;
            power_r <= 1'b0;
            track_r <= 1'b0;
        end
        else
        begin
            mux_r   <= chan_decode(sel_r, pair_r);
            power_r <= en_r;
            track_r <= track_nxt;
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    function automatic logic [7:0] read_mux(input logic [7:0] addr);
        unique case (addr)
            OFS_CTRL:  read_mux = {en_r, tm_r, done_r, busy, mode_r, irq_en_r, lj_r};
            OFS_CFG:   read_mux = {scale_r, 2'b00, gain_r};
            OFS_SEL:   read_mux = {4'h0, sel_r};
            OFS_PAIR:  read_mux = {4'h0, pair_r};
            OFS_RES_H: read_mux = lj_r ? result_r[11:4] : {4'h0, result_r[11:8]};
            OFS_RES_L: read_mux = lj_r ? {result_r[3:0], 4'h0} : result_r[7:0];
            default:   read_mux = 8'h00;
        endcase
    endfunction

    logic [7:0] rdata_r;

    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            rdata_r <= 8'h00;
        end
        else if (SFR_RE_I)
        begin
            rdata_r <= read_mux(SFR_ADDR_I);
        end
    end

    assign SFR_RDATA_O  = rdata_r;
    assign CONV_POWER_O = power_r;
    assign TRACK_O      = track_r;
    assign TEMP_SEL_O   = mux_r[7];
    assign DIFF_O       = mux_r[6];
    assign MUX_NEG_O    = mux_r[5:3];
    assign MUX_POS_O    = mux_r[2:0];
    assign GAIN_O       = gain_r;
    assign SAR_CODE_O   = trial_r;
    assign IRQ_O        = irq_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [8:0] gap_r;

    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            gap_r <= 9'h1ff;
        end
        else if (start_go)
        begin
            gap_r <= 9'h000;
        end
        else if (gap_r != 9'h1ff)
        begin
            gap_r <= gap_r + 9'h001;
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    sequence seq_start;
        (state_r == ST_IDLE) ##1 (state_r != ST_IDLE);
    endsequence

    sequence seq_track_end;
        (state_r == ST_TRACK) && tif.tick && (trk_cnt_r == TRACK_LAST);
    endsequence

    a_power_off_idle: assert property (!en_r |=> !busy && !CONV_POWER_O)
        else $error("converter active while disabled");
    a_temp_gain: assert property (sel_r[3] && !wr_cfg
        |=> TEMP_SEL_O && GAIN_O == $past(gain_r))
        else $error("sensor channel lost gain or select");
    a_pair_diff: assert property (!sel_r[3] && pair_r[sel_r[2:1]] |=> DIFF_O && !MUX_POS_O[0] && MUX_NEG_O[0])
        else $error("pair not decoded as differential");
    a_start_source: assert property (seq_start |-> $past(trig) && $past(en_r))
        else $error("conversion began without selected trigger");
    a_track_three: assert property (seq_track_end |=> state_r == ST_CONV)
        else $error("tracking did not end after three ticks");
    a_busy_done: assert property ($fell(busy) |=> done_r ##1 (IRQ_O == irq_en_r))
        else $error("completion did not raise flag");
    a_rate_gap: assert property (start_go |-> gap_r >= CONV_MIN_CYC - 1)
        else $error("conversion rate above limit");
    a_track_cont: assert property (en_r && !tm_r && !SLEEP_I && !busy |=> TRACK_O)
        else $error("continuous tracking missing");
    a_ext_track: assert property (tm_r && mode_r == START_EXT && busy |=> !TRACK_O)
        else $error("tracking during external conversion");

endmodule

`default_nettype wire

// ---- design/sar_ctl_pkg.sv ----
/*
 * constants, register map and types for the converter control block.
 * assumes one 20 MHz clock and an 8-bit special function register port.
 */
`default_nettype none

package sar_ctl_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS  = 50;
    localparam int CONV_PERIOD_NS = 10000;
    localparam int CONV_MIN_CYC   = (CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RATE_LOAD  = 8'(CONV_MIN_CYC - 1);
    localparam logic [1:0] TRACK_LAST = 2'h2;
    localparam logic [3:0] MSB_INDEX  = 4'hb;
    localparam logic [11:0] TRIAL_INIT = 12'h800;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_CFG   = 8'h01;
    localparam logic [7:0] OFS_SEL   = 8'h02;
    localparam logic [7:0] OFS_PAIR  = 8'h03;
    localparam logic [7:0] OFS_RES_H = 8'h04;
    localparam logic [7:0] OFS_RES_L = 8'h05;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int BIT_EN    = 7;
    localparam int BIT_TM    = 6;
    localparam int BIT_DONE  = 5;
    localparam int BIT_BUSY  = 4;
    localparam int BIT_MODE  = 2;
    localparam int BIT_IRQEN = 1;
    localparam int BIT_LJ    = 0;
    localparam int BIT_SCALE = 5;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CFG_RST  = 8'h60;
    localparam logic [3:0] SEL_RST  = 4'h0;
    localparam logic [3:0] PAIR_RST = 4'h0;

    typedef enum logic [1:0] {
        START_SW   = 2'h0,
        START_TMR3 = 2'h1,
        START_EXT  = 2'h2,
        START_TMR2 = 2'h3
    } start_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_TRACK = 3'b010,
        ST_CONV  = 3'b100
    } conv_state_t;

endpackage

`default_nettype wire
